/* File: ccfg_pkg.sv */
// Constants, field layout and types for the option word decoder.
// Assumes a 125 MHz system clock and option storage on that same clock.
package ccfg_pkg;

  localparam int OPT_WORDS = 3;
  localparam int OPT_W = 13;

  // Word 0 fields
  localparam int W0_RESET_PIN = 12;
  localparam int W0_WDT_EN_N = 11;
  localparam int W0_INSTR = 10;
  localparam int W0_LVR_HI = 9;
  localparam int W0_LVR_LO = 8;
  localparam int W0_SPARE_A = 7;
  localparam int W0_WDT_HI = 6;
  localparam int W0_WDT_LO = 5;
  localparam int W0_SPARE_B = 4;
  localparam int W0_SPARE_C = 3;
  localparam int W0_PROT_HI = 2;
  localparam int W0_PROT_LO = 0;
  localparam logic [2:0] PROT_OFF = 3'h7;

  // Word 1 fields
  localparam int W1_TRIM_HI = 11;
  localparam int W1_TRIM_LO = 7;
  localparam int W1_IRC_HI = 6;
  localparam int W1_IRC_LO = 5;
  localparam int W1_OSC_HI = 2;
  localparam int W1_OSC_LO = 1;

  // Low-voltage reset codes
  localparam logic [1:0] LVR_POR_ONLY = 2'h3;

  // Watchdog timeout codes and nominal times
  localparam logic [1:0] WDT_SEL_A = 2'h3;
  localparam logic [1:0] WDT_SEL_B = 2'h2;
  localparam logic [1:0] WDT_SEL_C = 2'h1;
  localparam real WDT_MS_A = 23.5;
  localparam real WDT_MS_B = 5.9;
  localparam real WDT_MS_C = 376.0;
  localparam real WDT_MS_D = 94.0;
  localparam real CLK_MHZ = 125.0;
  localparam int WDT_CYC_A = int'($floor(WDT_MS_A * CLK_MHZ * 1000.0));
  localparam int WDT_CYC_B = int'($floor(WDT_MS_B * CLK_MHZ * 1000.0));
  localparam int WDT_CYC_C = int'($floor(WDT_MS_C * CLK_MHZ * 1000.0));
  localparam int WDT_CYC_D = int'($floor(WDT_MS_D * CLK_MHZ * 1000.0));

  // Internal RC frequency codes and values in kHz
  localparam logic [1:0] IRC_SEL_4M = 2'h3;
  localparam logic [1:0] IRC_SEL_8M = 2'h2;
  localparam logic [1:0] IRC_SEL_1M = 2'h1;
  localparam logic [13:0] IRC_KHZ_4M = 14'h0fa0;
  localparam logic [13:0] IRC_KHZ_8M = 14'h1f40;
  localparam logic [13:0] IRC_KHZ_1M = 14'h03e8;
  localparam logic [13:0] IRC_KHZ_455K = 14'h01c7;

  // Clock divisions per instruction
  localparam logic [2:0] DIV_TWO = 3'h2;
  localparam logic [2:0] DIV_FOUR = 3'h4;

  typedef enum logic [1:0] {
    CCFG_OSC_LOW_CRYSTAL = 2'b00,
    CCFG_OSC_HIGH_CRYSTAL = 2'b01,
    CCFG_OSC_EXTERNAL_RC = 2'b10,
    CCFG_OSC_INTERNAL_RC = 2'b11
  } ccfg_osc_mode_t;

  typedef enum logic [1:0] {
    CCFG_RD_IDLE = 2'b00,
    CCFG_RD_ISSUE = 2'b01,
    CCFG_RD_WAIT = 2'b10
  } ccfg_rd_state_t;

  // Register map, byte addresses
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_LOADS = 4'h8;
  localparam int ST_LOADED = 0;
  localparam int ST_CORE_HOLD = 1;
  localparam int ST_PIN_RESET = 2;
  localparam int ST_SPARE_BAD = 3;
  localparam int ST_LOADING = 4;
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_HOLD = 1;
  localparam logic [31:0] RDATA_RST = 32'h0;
  localparam logic [7:0] LOADS_RST = 8'h0;

endpackage

/* File: ccfg_rd_if.sv */
// Link between the option word reader and the decoder top.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface ccfg_rd_if;
  logic start;
  logic busy;
  logic done;
  logic [ccfg_pkg::OPT_WORDS-1:0][ccfg_pkg::OPT_W-1:0] words;

  modport reader (input start, output busy, output done, output words);
  modport top (output start, input busy, input done, input words);
endinterface

/* File: ccfg_reader.sv */
// Sequencer that fetches the three option words from option storage.
// Assumes storage answers each read with one valid pulse on the same clock.
`timescale 1ns/1ns
module ccfg_reader (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Top side
  ccfg_rd_if.reader rd,
  // Option storage port
  output logic o_nvm_rd,
  output logic [1:0] o_nvm_addr,
  input wire logic [ccfg_pkg::OPT_W-1:0] i_nvm_data,
  input wire logic i_nvm_valid
);

  ccfg_pkg::ccfg_rd_state_t state_reg;
  logic [1:0] idx_reg;
  logic [ccfg_pkg::OPT_WORDS-1:0][ccfg_pkg::OPT_W-1:0] words_reg;
  logic done_reg;
  logic last;

  assign last = (idx_reg == 2'(ccfg_pkg::OPT_WORDS - 1));

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ccfg_pkg::CCFG_RD_ISSUE;
      idx_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        ccfg_pkg::CCFG_RD_IDLE: begin
          if (rd.start) begin
            state_reg <= ccfg_pkg::CCFG_RD_ISSUE;
            idx_reg <= 2'h0;
          end
        end
        ccfg_pkg::CCFG_RD_ISSUE: begin
          state_reg <= ccfg_pkg::CCFG_RD_WAIT;
        end
        ccfg_pkg::CCFG_RD_WAIT: begin
          if (i_nvm_valid) begin
            state_reg <= last ? ccfg_pkg::CCFG_RD_IDLE
                              : ccfg_pkg::CCFG_RD_ISSUE;
            idx_reg <= last ? 2'h0 : idx_reg + 2'h1;
          end
        end
        default: begin
          state_reg <= ccfg_pkg::CCFG_RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_nvm_rd <= 1'b0;
      o_nvm_addr <= 2'h0;
    end else begin
      o_nvm_rd <= (state_reg == ccfg_pkg::CCFG_RD_ISSUE);
      o_nvm_addr <= idx_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      words_reg <= '1;
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == ccfg_pkg::CCFG_RD_WAIT) && i_nvm_valid
                  && last;
      if ((state_reg == ccfg_pkg::CCFG_RD_WAIT) && i_nvm_valid) begin
        words_reg[idx_reg] <= i_nvm_data;
      end
    end
  end

  assign rd.words = words_reg;
  assign rd.done = done_reg;
  assign rd.busy = (state_reg != ccfg_pkg::CCFG_RD_IDLE);

endmodule // ccfg_reader

/* File: ccfg_top.sv */
// Option word decoder: fetches, latches and decodes static configuration.
// Assumes option storage and the Avalon master share i_clk; the reset pin
// is asynchronous to it.
`timescale 1ns/1ns
module ccfg_top #(
  parameter int unsigned WDT_CYC_A = ccfg_pkg::WDT_CYC_A,
  parameter int unsigned WDT_CYC_B = ccfg_pkg::WDT_CYC_B,
  parameter int unsigned WDT_CYC_C = ccfg_pkg::WDT_CYC_C,
  parameter int unsigned WDT_CYC_D = ccfg_pkg::WDT_CYC_D
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Option storage
  output logic o_nvm_rd,
  output logic [1:0] o_nvm_addr,
  input wire logic [ccfg_pkg::OPT_W-1:0] i_nvm_data,
  input wire logic i_nvm_valid,
  // Shared reset pin
  input wire logic i_reset_pin_n,
  // Core control
  output logic o_core_hold,
  output logic o_cfg_valid,
  // Decoded configuration
  output logic o_reset_pin_select,
  output logic o_pin_reset_req,
  output logic o_watchdog_enable,
  output logic [1:0] o_wdt_period_sel,
  output logic [31:0] o_wdt_timeout_cycles,
  output logic o_instr_period_select,
  output logic [2:0] o_instr_clocks,
  output logic [2:0] o_timer_counter_div,
  output logic o_lvr_enable,
  output logic [1:0] o_lvr_level,
  output logic o_code_protect,
  output logic [1:0] o_irc_freq_sel,
  output logic [13:0] o_irc_freq_khz,
  output logic [4:0] o_irc_trim_bits,
  output logic o_low_crystal_mode,
  output logic o_high_crystal_mode,
  output logic o_external_rc_mode,
  output logic o_internal_rc_mode
);

  ccfg_rd_if rd ();

  logic [ccfg_pkg::OPT_W-1:0] w0;
  logic [ccfg_pkg::OPT_W-1:0] w1;
  logic start_reg;
  logic loaded_reg;
  logic hold_reg;
  logic [7:0] loads_reg;
  logic pin_s1_reg;
  logic pin_s2_reg;
  logic spare_bad_reg;
  logic req;
  logic take;
  logic ctrl_wr;
  logic [1:0] wdt_sel;
  logic [1:0] irc_sel;
  ccfg_pkg::ccfg_osc_mode_t osc_mode;

  ccfg_reader u_reader (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .rd(rd.reader),
    .o_nvm_rd(o_nvm_rd),
    .o_nvm_addr(o_nvm_addr),
    .i_nvm_data(i_nvm_data),
    .i_nvm_valid(i_nvm_valid)
  );

  assign w0 = rd.words[0];
  assign w1 = rd.words[1];
  assign rd.start = start_reg;
  assign wdt_sel = w0[ccfg_pkg::W0_WDT_HI:ccfg_pkg::W0_WDT_LO];
  assign irc_sel = w1[ccfg_pkg::W1_IRC_HI:ccfg_pkg::W1_IRC_LO];
  assign osc_mode =
    ccfg_pkg::ccfg_osc_mode_t'(w1[ccfg_pkg::W1_OSC_HI:ccfg_pkg::W1_OSC_LO]);

  // Bus request handling
  assign req = i_avs_read || i_avs_write;
  assign take = req && !o_avs_waitrequest;
  assign ctrl_wr = take && i_avs_write && i_avs_byteenable[0]
                   && (i_avs_address == ccfg_pkg::REG_CTRL);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !(req && o_avs_waitrequest);
    end
  end

  // Option bits never reach the bus
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_readdata <= ccfg_pkg::RDATA_RST;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= ccfg_pkg::RDATA_RST;
      unique case (i_avs_address)
        ccfg_pkg::REG_STATUS: begin
          o_avs_readdata[ccfg_pkg::ST_LOADED] <= loaded_reg;
          o_avs_readdata[ccfg_pkg::ST_CORE_HOLD] <= o_core_hold;
          o_avs_readdata[ccfg_pkg::ST_PIN_RESET] <= o_pin_reset_req;
          o_avs_readdata[ccfg_pkg::ST_SPARE_BAD] <= spare_bad_reg;
          o_avs_readdata[ccfg_pkg::ST_LOADING] <= rd.busy;
        end
        ccfg_pkg::REG_CTRL: begin
          o_avs_readdata[ccfg_pkg::CTRL_HOLD] <= hold_reg;
        end
        ccfg_pkg::REG_LOADS: begin
          o_avs_readdata[7:0] <= loads_reg;
        end
        default: begin
          o_avs_readdata <= ccfg_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // Control register: reload pulse and hold bit
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hold_reg <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= ctrl_wr && i_avs_writedata[ccfg_pkg::CTRL_RELOAD]
                   && !rd.busy;
      if (ctrl_wr) begin
        hold_reg <= i_avs_writedata[ccfg_pkg::CTRL_HOLD];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      loaded_reg <= 1'b0;
      loads_reg <= ccfg_pkg::LOADS_RST;
    end else if (start_reg) begin
      loaded_reg <= 1'b0;
    end else if (rd.done) begin
      loaded_reg <= 1'b1;
      loads_reg <= loads_reg + 8'h1;
    end
  end

  // Reset pin synchroniser
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_s1_reg <= 1'b1;
      pin_s2_reg <= 1'b1;
    end else begin
      pin_s1_reg <= i_reset_pin_n;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pin_reset_req <= 1'b0;
      o_core_hold <= 1'b1;
    end else begin
      o_pin_reset_req <= o_cfg_valid && !o_reset_pin_select && !pin_s2_reg;
      o_core_hold <= !o_cfg_valid || hold_reg || o_pin_reset_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_cfg_valid <= 1'b0;
      o_reset_pin_select <= 1'b1;
      o_watchdog_enable <= 1'b0;
      o_wdt_period_sel <= ccfg_pkg::WDT_SEL_A;
      o_instr_period_select <= 1'b0;
      o_lvr_level <= ccfg_pkg::LVR_POR_ONLY;
      o_code_protect <= 1'b0;
      o_irc_freq_sel <= ccfg_pkg::IRC_SEL_4M;
      o_irc_trim_bits <= 5'h1f;
      spare_bad_reg <= 1'b0;
    end else if (start_reg) begin
      o_cfg_valid <= 1'b0;
    end else if (rd.done) begin
      o_cfg_valid <= 1'b1;
      o_reset_pin_select <= w0[ccfg_pkg::W0_RESET_PIN];
      o_watchdog_enable <= !w0[ccfg_pkg::W0_WDT_EN_N];
      o_wdt_period_sel <= wdt_sel;
      o_instr_period_select <= w0[ccfg_pkg::W0_INSTR];
      o_lvr_level <= w0[ccfg_pkg::W0_LVR_HI:ccfg_pkg::W0_LVR_LO];
      o_code_protect <= (w0[ccfg_pkg::W0_PROT_HI:ccfg_pkg::W0_PROT_LO]
                         != ccfg_pkg::PROT_OFF);
      o_irc_freq_sel <= irc_sel;
      o_irc_trim_bits <= w1[ccfg_pkg::W1_TRIM_HI:ccfg_pkg::W1_TRIM_LO];
      // Flag spare bits not left at one
      spare_bad_reg <= !(w0[ccfg_pkg::W0_SPARE_A] && w0[ccfg_pkg::W0_SPARE_B]
                         && w0[ccfg_pkg::W0_SPARE_C]);
    end
  end

  // Two or four clocks per instruction
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_instr_clocks <= ccfg_pkg::DIV_TWO;
      o_timer_counter_div <= ccfg_pkg::DIV_TWO;
    end else if (rd.done && !start_reg) begin
      o_instr_clocks <= w0[ccfg_pkg::W0_INSTR] ? ccfg_pkg::DIV_FOUR
                                               : ccfg_pkg::DIV_TWO;
      o_timer_counter_div <= w0[ccfg_pkg::W0_INSTR] ? ccfg_pkg::DIV_FOUR
                                                    : ccfg_pkg::DIV_TWO;
    end
  end

  // Low-voltage reset on unless code 11
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_lvr_enable <= 1'b0;
    end else if (rd.done && !start_reg) begin
      o_lvr_enable <= (w0[ccfg_pkg::W0_LVR_HI:ccfg_pkg::W0_LVR_LO]
                       != ccfg_pkg::LVR_POR_ONLY);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_wdt_timeout_cycles <= 32'(WDT_CYC_A);
    end else if (rd.done && !start_reg) begin
      unique case (wdt_sel)
        ccfg_pkg::WDT_SEL_A: o_wdt_timeout_cycles <= 32'(WDT_CYC_A);
        ccfg_pkg::WDT_SEL_B: o_wdt_timeout_cycles <= 32'(WDT_CYC_B);
        ccfg_pkg::WDT_SEL_C: o_wdt_timeout_cycles <= 32'(WDT_CYC_C);
        default: o_wdt_timeout_cycles <= 32'(WDT_CYC_D);
      endcase
    end
  end

  // Internal RC defaults to 4 MHz
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_irc_freq_khz <= ccfg_pkg::IRC_KHZ_4M;
    end else if (rd.done && !start_reg) begin
      unique case (irc_sel)
        ccfg_pkg::IRC_SEL_4M: o_irc_freq_khz <= ccfg_pkg::IRC_KHZ_4M;
        ccfg_pkg::IRC_SEL_8M: o_irc_freq_khz <= ccfg_pkg::IRC_KHZ_8M;
        ccfg_pkg::IRC_SEL_1M: o_irc_freq_khz <= ccfg_pkg::IRC_KHZ_1M;
        default: o_irc_freq_khz <= ccfg_pkg::IRC_KHZ_455K;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_low_crystal_mode <= 1'b0;
      o_high_crystal_mode <= 1'b0;
      o_external_rc_mode <= 1'b0;
      o_internal_rc_mode <= 1'b1;
    end else if (rd.done && !start_reg) begin
      o_low_crystal_mode <= (osc_mode == ccfg_pkg::CCFG_OSC_LOW_CRYSTAL);
      o_high_crystal_mode <= (osc_mode == ccfg_pkg::CCFG_OSC_HIGH_CRYSTAL);
      o_external_rc_mode <= (osc_mode == ccfg_pkg::CCFG_OSC_EXTERNAL_RC);
      o_internal_rc_mode <= (osc_mode == ccfg_pkg::CCFG_OSC_INTERNAL_RC);
    end
  end

endmodule // ccfg_top

/* File: ccfg_top_assertions.sv */
// Concurrent checks on the option decoder top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ccfg_top_assertions #(
  parameter int unsigned WDT_CYC_A = ccfg_pkg::WDT_CYC_A,
  parameter int unsigned WDT_CYC_B = ccfg_pkg::WDT_CYC_B,
  parameter int unsigned WDT_CYC_C = ccfg_pkg::WDT_CYC_C,
  parameter int unsigned WDT_CYC_D = ccfg_pkg::WDT_CYC_D
) (
  // Clock, reset, bus
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Storage, pin, core
  input wire logic o_nvm_rd,
  input wire logic i_reset_pin_n,
  input wire logic o_core_hold,
  input wire logic o_cfg_valid,
  input wire logic o_reset_pin_select,
  input wire logic o_pin_reset_req,
  // Decoded fields
  input wire logic [1:0] o_wdt_period_sel,
  input wire logic [31:0] o_wdt_timeout_cycles,
  input wire logic o_instr_period_select,
  input wire logic [2:0] o_instr_clocks,
  input wire logic [2:0] o_timer_counter_div,
  input wire logic o_lvr_enable,
  input wire logic [1:0] o_lvr_level,
  input wire logic [1:0] o_irc_freq_sel,
  input wire logic [13:0] o_irc_freq_khz,
  input wire logic [4:0] o_irc_trim_bits,
  input wire logic o_low_crystal_mode,
  input wire logic o_high_crystal_mode,
  input wire logic o_external_rc_mode,
  input wire logic o_internal_rc_mode
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  AST_WREQ_PULSE: assert property (!o_avs_waitrequest |=>
    o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_WREQ_ANSWER: assert property ((i_avs_read || i_avs_write) &&
    o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered next cycle");
  AST_NVM_PULSE: assert property (o_nvm_rd |=> !o_nvm_rd)
    else $error("storage read longer than one cycle");
  AST_WDT_MAP: assert property (o_wdt_timeout_cycles ==
    ((o_wdt_period_sel == 2'h3) ? WDT_CYC_A :
     (o_wdt_period_sel == 2'h2) ? WDT_CYC_B :
     (o_wdt_period_sel == 2'h1) ? WDT_CYC_C : WDT_CYC_D))
    else $error("watchdog timeout does not match its code");
  AST_IRC_MAP: assert property (o_irc_freq_khz ==
    ((o_irc_freq_sel == 2'h3) ? 14'hfa0 :
     (o_irc_freq_sel == 2'h2) ? 14'h1f40 :
     (o_irc_freq_sel == 2'h1) ? 14'h3e8 : 14'h1c7))
    else $error("internal RC frequency does not match its code");
  AST_INSTR_DIV: assert property (
    o_timer_counter_div == o_instr_clocks &&
    o_instr_clocks == (o_instr_period_select ? 3'h4 : 3'h2))
    else $error("instruction clocks or timer divider wrong");
  AST_LVR_EN: assert property (o_lvr_enable == (o_lvr_level != 2'h3))
    else $error("low-voltage reset enable wrong");
  AST_OSC_ONEHOT: assert property ($onehot({o_low_crystal_mode,
    o_high_crystal_mode, o_external_rc_mode, o_internal_rc_mode}))
    else $error("oscillator modes not one-hot");
  AST_PIN_REQ: assert property (o_pin_reset_req |->
    !o_reset_pin_select ##1 o_core_hold)
    else $error("pin reset request without select or hold");
  AST_PIN_LAT: assert property ($fell(i_reset_pin_n) && o_cfg_valid &&
    !o_reset_pin_select |-> ##[2:4] o_pin_reset_req)
    else $error("pin reset not seen in time");
  AST_HOLD_LOAD: assert property (!o_cfg_valid |=> o_core_hold)
    else $error("core released before options loaded");
  AST_CFG_STABLE: assert property (
    o_cfg_valid && $past(o_cfg_valid) |->
    $stable(o_irc_trim_bits) && $stable(o_reset_pin_select) &&
    $stable(o_wdt_period_sel) && $stable(o_lvr_level))
    else $error("configuration changed while valid");
endmodule // ccfg_top_assertions

bind ccfg_top ccfg_top_assertions #(.WDT_CYC_A(WDT_CYC_A),
  .WDT_CYC_B(WDT_CYC_B), .WDT_CYC_C(WDT_CYC_C), .WDT_CYC_D(WDT_CYC_D))
  u_ccfg_top_assertions (.*);

/* File: test_code_option_config_decode.sv */
// Self-checking bench for the option word decoder top.
// Assumes ccfg_pkg and the design files are compiled first.
`timescale 1ns/1ns
module test_code_option_config_decode;
  logic i_clk, i_srst, i_avs_read, i_avs_write, i_nvm_valid, i_reset_pin_n;
  logic [3:0] i_avs_address, i_avs_byteenable;
  logic [31:0] i_avs_writedata, o_avs_readdata, o_wdt_timeout_cycles, rd;
  logic [12:0] i_nvm_data, w0, w1;
  logic o_avs_waitrequest, o_nvm_rd, o_core_hold, o_cfg_valid;
  logic o_reset_pin_select, o_pin_reset_req, o_watchdog_enable;
  logic o_instr_period_select, o_lvr_enable, o_code_protect;
  logic o_low_crystal_mode, o_high_crystal_mode;
  logic o_external_rc_mode, o_internal_rc_mode;
  logic [1:0] o_nvm_addr, o_wdt_period_sel, o_lvr_level, o_irc_freq_sel;
  logic [2:0] o_instr_clocks, o_timer_counter_div;
  logic [13:0] o_irc_freq_khz;
  logic [4:0] o_irc_trim_bits;
  logic [12:0] words [3];
  int failures, checks_done, loads;
  int tmo [4] = '{32'h50, 32'hc8, 32'ha, 32'h28};
  int khz [4] = '{32'h1c7, 32'h3e8, 32'h1f40, 32'hfa0};

  ccfg_top #(.WDT_CYC_A(32'h28), .WDT_CYC_B(32'ha), .WDT_CYC_C(32'hc8),
    .WDT_CYC_D(32'h50)) u_ccfg_top (.*);

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Option storage answers each read after a random delay
  initial begin : nvm_side
    logic [1:0] a;
    i_nvm_valid = 1'b0;
    i_nvm_data = 13'h0;
    forever begin
      @(posedge i_clk);
      if (o_nvm_rd === 1'b1) begin
        a = o_nvm_addr;
        repeat ($urandom_range(3)) @(posedge i_clk);
        i_nvm_valid <= 1'b1;
        i_nvm_data <= words[a];
        @(posedge i_clk);
        i_nvm_valid <= 1'b0;
        i_nvm_data <= ~words[a];
      end
    end
  end

  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    if (o_avs_waitrequest !== 1'b0) begin
      failures++;
      stop_test();
    end
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    while (o_cfg_valid !== lvl && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    if (o_cfg_valid !== lvl) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic check_cfg;
    w0 = words[0];
    w1 = words[1];
    chk(o_reset_pin_select, w0[12]);
    chk(o_watchdog_enable, !w0[11]);
    chk(o_instr_period_select, w0[10]);
    chk(o_instr_clocks, w0[10] ? 32'h4 : 32'h2);
    chk(o_timer_counter_div, w0[10] ? 32'h4 : 32'h2);
    chk(o_lvr_level, w0[9:8]);
    chk(o_lvr_enable, w0[9:8] != 2'h3);
    chk(o_wdt_period_sel, w0[6:5]);
    chk(o_wdt_timeout_cycles, tmo[w0[6:5]]);
    chk(o_code_protect, w0[2:0] != 3'h7);
    chk(o_irc_freq_sel, w1[6:5]);
    chk(o_irc_freq_khz, khz[w1[6:5]]);
    chk(o_irc_trim_bits, w1[11:7]);
    chk({o_low_crystal_mode, o_high_crystal_mode, o_external_rc_mode,
         o_internal_rc_mode}, 32'h8 >> w1[2:1]);
    chk(o_cfg_valid, 32'h1);
  endtask

  initial begin
    i_srst = 1'b1;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_address = 4'h0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'hf;
    i_reset_pin_n = 1'b1;
    words = '{13'h1fff, 13'h1fff, 13'h0aa5};
    void'($urandom(40));
    repeat (16) @(posedge i_clk);
    chk(o_core_hold, 32'h1);
    chk(o_internal_rc_mode, 32'h1);
    chk(o_avs_waitrequest, 32'h1);
    i_srst <= 1'b0;
    wait_valid(1'b1);
    check_cfg();
    loads = 1;
    for (int i = 0; i < 8; i++) begin
      w0 = 13'($urandom);
      w1 = 13'($urandom);
      w0[12] = i[0];
      w0[9:8] = i[1:0];
      w0[6:5] = ~i[1:0];
      {w0[7], w0[4], w0[3]} = (i == 5) ? 3'h0 : 3'h7;
      if (i == 7)
        w0[2:0] = 3'h7;
      w1[6:5] = i[2:1];
      w1[2:1] = i[1:0];
      words[0] = w0;
      words[1] = w1;
      words[2] = 13'($urandom);
      bus(1'b1, 4'h4, 32'h1, 4'hf);
      wait_valid(1'b0);
      wait_valid(1'b1);
      loads++;
      check_cfg();
      bus(1'b0, 4'h8, 32'h0, 4'hf);
      chk(rd, loads & 32'hff);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, (i == 5) ? 32'h9 : 32'h1);
      i_reset_pin_n <= 1'b0;
      repeat (6) @(posedge i_clk);
      chk(o_pin_reset_req, !w0[12]);
      chk(o_core_hold, !w0[12]);
      i_reset_pin_n <= 1'b1;
      repeat (6) @(posedge i_clk);
      chk(o_core_hold, 32'h0);
    end
    bus(1'b1, 4'h4, 32'h2, 4'h0);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b1, 4'hc, 32'h2, 4'hf);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b1, 4'h4, 32'h2, 4'hf);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h2);
    chk(o_core_hold, 32'h1);
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    repeat (2) @(posedge i_clk);
    chk(o_core_hold, 32'h0);
    stop_test();
  end
endmodule // test_code_option_config_decode
